/* shared/apds_pkg.sv */
package apds_pkg;

// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
localparam logic [3:0] ADDR_CTRL = 4'h0;
localparam logic [3:0] ADDR_STATUS = 4'h4;
localparam logic [3:0] ADDR_RESULT = 4'h8;
localparam logic [3:0] ADDR_SAMPLE = 4'hc;
localparam logic [1:0] RESP_OKAY = 2'h0;
localparam logic [1:0] RESP_SLVERR = 2'h2;

// ---------------------------------------------------------------
// control byte fields
// ---------------------------------------------------------------
localparam int POWER_SEL_HI_BIT = 7;
localparam int POWER_SEL_LO_BIT = 6;
localparam int ACQ_MODE_BIT = 5;
localparam int SINGLE_ENDED_BIT = 4;
localparam int UNIPOLAR_SELECT_BIT = 3;
localparam logic [1:0] CODE_INT_CLK = 2'h2;
localparam logic [1:0] CODE_EXT_CLK = 2'h3;
localparam logic [1:0] CODE_STANDBY = 2'h0;
localparam logic [1:0] CODE_SHUTDOWN = 2'h1;
localparam logic [7:0] CTRL_RESET = 8'hc0;

// ---------------------------------------------------------------
// conversion schedule, in conversion clock cycles
// ---------------------------------------------------------------
localparam logic [4:0] CYC_WRITE = 5'h01;
localparam logic [4:0] CYC_ACQ = 5'h03;
localparam logic [4:0] CYC_CONV = 5'h0d;
localparam logic [4:0] CYC_READ = 5'h02;
localparam logic [4:0] CYC_FULL = 5'h13;
localparam logic [4:0] CYC_PIPE = 5'h10;

// ---------------------------------------------------------------
// timing: system clock 40 MHz; external conversion clock 4.8 MHz
// ---------------------------------------------------------------
localparam int SYS_CLK_KHZ = 40000;
localparam int CONV_CLK_KHZ = 4800;
localparam int CONV_DIV = SYS_CLK_KHZ / CONV_CLK_KHZ;
localparam logic [3:0] CONV_DIV_CNT = 4'(CONV_DIV);
localparam int SETTLE_INT_US = 500;
localparam int SETTLE_EXT_US = 50;
localparam int SETTLE_INT_CYC = SETTLE_INT_US * (SYS_CLK_KHZ / 1000);
localparam int SETTLE_EXT_CYC = SETTLE_EXT_US * (SYS_CLK_KHZ / 1000);

typedef enum logic [1:0] {
    PWR_FULL,
    PWR_STANDBY,
    PWR_SHUTDOWN
} apds_pwr_e;

typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ACQ,
    SEQ_CONV
} apds_seq_e;

endpackage

/* hdl/apds_top.sv */
// Operation
// - top two control bits choose low-power state
// - low power keeps port alive, no conversion
// - standby wakes on next write strobe edge
// - shutdown waits for running conversion to finish
// - write strobe edge leaves shutdown
// - unipolar result is straight binary
// - full conversion spans nineteen clock cycles
// - top bits also choose conversion clock source
// - low-power codes keep last clock source
// - bipolar two's complement, high byte extends
//
// The AXI4-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module apds_top #(
    parameter int SETTLE_INT_CYCLES = apds_pkg::SETTLE_INT_CYC,
    parameter int SETTLE_EXT_CYCLES = apds_pkg::SETTLE_EXT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [11:0] sample_in,
    output logic [2:0] channel_sel,
    output logic analog_on,
    output logic conv_busy
);

// ---------------------------------------------------------------
// state
// ---------------------------------------------------------------
logic [7:0] ctrl_q;
logic ext_clk_q;
apds_pkg::apds_pwr_e pwr_q;
apds_pkg::apds_seq_e seq_q;
logic shutdown_pend_q;
logic standby_pend_q;
logic [4:0] cyc_q;
logic [3:0] div_q;
logic [11:0] result_q;
logic result_new_q;
logic [31:0] settle_q;
logic [4:0] last_span_q;
logic aw_got_q, w_got_q;
logic [3:0] awaddr_q;
logic [31:0] wdata_q;
logic [3:0] wstrb_q;

logic wr_fire, wr_ctrl, rd_fire, rd_result_lo, rd_result_hi;
logic [1:0] pd_code;
logic conv_tick, conv_done;

// ---------------------------------------------------------------
// address decode
// ---------------------------------------------------------------
// never a mapped offset: marks an address outside the map
localparam logic [3:0] REG_NONE = 4'h1;

// word-aligned register offset; addresses past the map decode to none
function automatic logic [3:0] reg_sel(input logic [31:0] addr);
    logic [3:0] idx;
    idx = REG_NONE;
    if (addr[31:4] == 28'h0) begin
        idx = {addr[3:2], 2'b00};
    end
    return idx;
endfunction

// ---------------------------------------------------------------
// axi4-lite write channel
// ---------------------------------------------------------------
assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
assign s_axi_wready = !w_got_q && !s_axi_bvalid;
assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
assign wr_ctrl = wr_fire && awaddr_q == apds_pkg::ADDR_CTRL && wstrb_q[0];
assign pd_code = {wdata_q[apds_pkg::POWER_SEL_HI_BIT], wdata_q[apds_pkg::POWER_SEL_LO_BIT]};

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        awaddr_q <= 4'h0;
        wdata_q <= 32'h0;
        wstrb_q <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= apds_pkg::RESP_OKAY;
    end else begin
        if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q <= 1'b1;
            awaddr_q <= reg_sel(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == apds_pkg::ADDR_CTRL) begin
                s_axi_bresp <= apds_pkg::RESP_OKAY;
            end else begin
                s_axi_bresp <= apds_pkg::RESP_SLVERR;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ---------------------------------------------------------------
// control byte and clock source
// ---------------------------------------------------------------
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        ctrl_q <= apds_pkg::CTRL_RESET;
        ext_clk_q <= 1'b1;
    end else if (wr_ctrl) begin
        ctrl_q <= wdata_q[7:0];
        if (pd_code == apds_pkg::CODE_EXT_CLK) begin
            ext_clk_q <= 1'b1;
        end else if (pd_code == apds_pkg::CODE_INT_CLK) begin
            ext_clk_q <= 1'b0;
        end
    end
end

assign channel_sel = ctrl_q[2:0];

// ---------------------------------------------------------------
// power state
// ---------------------------------------------------------------
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        pwr_q <= apds_pkg::PWR_FULL;
        shutdown_pend_q <= 1'b0;
        standby_pend_q <= 1'b0;
    end else if (wr_ctrl && pwr_q != apds_pkg::PWR_FULL) begin
        // a write out of low power only wakes; it starts nothing
        pwr_q <= apds_pkg::PWR_FULL;
        shutdown_pend_q <= 1'b0;
        standby_pend_q <= 1'b0;
    end else if (wr_ctrl && pd_code == apds_pkg::CODE_SHUTDOWN) begin
        shutdown_pend_q <= 1'b1;
        standby_pend_q <= 1'b0;
    end else if (wr_ctrl && pd_code == apds_pkg::CODE_STANDBY) begin
        // dummy conversion runs at full power, standby follows it
        shutdown_pend_q <= 1'b0;
        standby_pend_q <= 1'b1;
    end else if (shutdown_pend_q && (seq_q == apds_pkg::SEQ_IDLE || conv_done)) begin
        pwr_q <= apds_pkg::PWR_SHUTDOWN;
        shutdown_pend_q <= 1'b0;
    end else if (standby_pend_q && (seq_q == apds_pkg::SEQ_IDLE || conv_done)) begin
        pwr_q <= apds_pkg::PWR_STANDBY;
        standby_pend_q <= 1'b0;
    end
end

assign analog_on = pwr_q == apds_pkg::PWR_FULL;

// ---------------------------------------------------------------
// conversion sequencer
// ---------------------------------------------------------------
assign conv_tick = div_q == 4'h0;
assign conv_done = seq_q == apds_pkg::SEQ_CONV && conv_tick && cyc_q == 5'h01;
assign conv_busy = seq_q != apds_pkg::SEQ_IDLE;

always_ff @(posedge aclk) begin
    if (!aresetn || seq_q == apds_pkg::SEQ_IDLE || conv_tick) begin
        div_q <= apds_pkg::CONV_DIV_CNT - 4'h1;
    end else begin
        div_q <= div_q - 4'h1;
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        seq_q <= apds_pkg::SEQ_IDLE;
        cyc_q <= 5'h0;
        result_q <= 12'h0;
        last_span_q <= 5'h0;
    end else begin
        case (seq_q)
        apds_pkg::SEQ_IDLE: begin
            // a standby-coded write still samples: the dummy conversion
            if (wr_ctrl && pwr_q == apds_pkg::PWR_FULL) begin
                seq_q <= apds_pkg::SEQ_ACQ;
                cyc_q <= apds_pkg::CYC_ACQ;
                // budget: acquire + convert, plus write and read unless pipelined
                last_span_q <= result_new_q ? apds_pkg::CYC_PIPE : apds_pkg::CYC_FULL;
            end
        end
        apds_pkg::SEQ_ACQ: begin
            if (conv_tick) begin
                if (cyc_q == 5'h01) begin
                    seq_q <= apds_pkg::SEQ_CONV;
                    cyc_q <= apds_pkg::CYC_CONV;
                end else begin
                    cyc_q <= cyc_q - 5'h01;
                end
            end
        end
        apds_pkg::SEQ_CONV: begin
            if (conv_tick) begin
                if (cyc_q == 5'h01) begin
                    seq_q <= apds_pkg::SEQ_IDLE;
                    result_q <= sample_in;
                end else begin
                    cyc_q <= cyc_q - 5'h01;
                end
            end
        end
        default: seq_q <= apds_pkg::SEQ_IDLE;
        endcase
    end
end

// ---------------------------------------------------------------
// settling counter after wake-up
// ---------------------------------------------------------------
always_ff @(posedge aclk) begin
    if (!aresetn) begin
        settle_q <= 32'h0;
    end else if (wr_ctrl && pwr_q != apds_pkg::PWR_FULL) begin
        // clock source flag stands in for the reference choice
        settle_q <= ext_clk_q ? 32'(SETTLE_EXT_CYCLES) : 32'(SETTLE_INT_CYCLES);
    end else if (settle_q != 32'h0) begin
        settle_q <= settle_q - 32'h1;
    end
end

// ---------------------------------------------------------------
// axi4-lite read channel and result coding
// ---------------------------------------------------------------
assign s_axi_arready = !s_axi_rvalid;
assign rd_fire = s_axi_arvalid && s_axi_arready;
assign rd_result_lo = rd_fire && reg_sel(s_axi_araddr) == apds_pkg::ADDR_RESULT;
assign rd_result_hi = rd_fire && reg_sel(s_axi_araddr) == apds_pkg::ADDR_SAMPLE;

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        result_new_q <= 1'b0;
    end else if (conv_done) begin
        result_new_q <= 1'b1;
    end else if (rd_result_lo || rd_result_hi) begin
        result_new_q <= 1'b0;
    end
end

always_ff @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= apds_pkg::RESP_OKAY;
    end else if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= apds_pkg::RESP_OKAY;
        if (reg_sel(s_axi_araddr) == apds_pkg::ADDR_CTRL) begin
            s_axi_rdata <= {24'h0, ctrl_q};
        end else if (reg_sel(s_axi_araddr) == apds_pkg::ADDR_STATUS) begin
            s_axi_rdata <= {19'h0, last_span_q, (settle_q == 32'h0), result_new_q,
                            shutdown_pend_q, ext_clk_q, conv_busy, 1'b0, pwr_q};
        end else if (reg_sel(s_axi_araddr) == apds_pkg::ADDR_RESULT) begin
            s_axi_rdata <= {24'h0, result_q[7:0]};
        end else if (reg_sel(s_axi_araddr) == apds_pkg::ADDR_SAMPLE) begin
            // high byte: sign-extend in bipolar, zero in unipolar
            s_axi_rdata <= {24'h0,
                {4{result_q[11] & ~ctrl_q[apds_pkg::UNIPOLAR_SELECT_BIT]}},
                result_q[11:8]};
        end else begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= apds_pkg::RESP_SLVERR;
        end
    end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

endmodule

`default_nettype wire

/* verif/apds_chk_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module apds_chk #(
    parameter int SETTLE_INT_CYCLES = apds_pkg::SETTLE_INT_CYC,
    parameter int SETTLE_EXT_CYCLES = apds_pkg::SETTLE_EXT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic analog_on,
    input wire logic conv_busy
);
// ----------------------------------------
// power, conversion and bus handshake
// ----------------------------------------
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_busy_on; conv_busy |-> analog_on; endproperty
a_busy_on: assert property (p_busy_on)
    else $error("conversion while powered down");
property p_lp_no_conv; $rose(s_axi_bvalid) && !$past(analog_on) |-> !conv_busy[*2]; endproperty
a_lp_no_conv: assert property (p_lp_no_conv)
    else $error("write in low power started a conversion");
property p_wake;
    $rose(s_axi_bvalid) && s_axi_bresp == apds_pkg::RESP_OKAY && !$past(analog_on)
        |-> ##[0:1] analog_on;
endproperty
a_wake: assert property (p_wake)
    else $error("write did not wake the core");
property p_conv_min; $rose(conv_busy) |-> conv_busy[*8]; endproperty
a_conv_min: assert property (p_conv_min)
    else $error("conversion cut short");
property p_conv_len; $rose(conv_busy) |-> ##[100:160] !conv_busy; endproperty
a_conv_len: assert property (p_conv_len)
    else $error("conversion length out of range");
property p_conv_cause; $rose(conv_busy) |-> s_axi_bvalid && s_axi_bresp == apds_pkg::RESP_OKAY; endproperty
a_conv_cause: assert property (p_conv_cause)
    else $error("conversion began without a write");
property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
property p_r_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
a_r_ans: assert property (p_r_ans)
    else $error("read not answered");
endmodule
bind apds_top apds_chk #(
    .SETTLE_INT_CYCLES(SETTLE_INT_CYCLES),
    .SETTLE_EXT_CYCLES(SETTLE_EXT_CYCLES)
) u_chk (.aclk, .aresetn, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .analog_on, .conv_busy);
`default_nettype wire

/* verif/apds_core_model.sv */
`timescale 1ns/100ps
`default_nettype none
module apds_core_model (
    input wire logic aclk,
    input wire logic analog_on,
    input wire logic [11:0] code,
    output logic [11:0] sample_in = 12'h000
);
// ----------------------------------------
// analog core: no valid code when off
// ----------------------------------------
always_ff @(posedge aclk) begin
    sample_in <= analog_on ? code : ~sample_in;
end
endmodule
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
localparam logic [31:0] A_C = 32'(apds_pkg::ADDR_CTRL);
localparam logic [31:0] A_S = 32'(apds_pkg::ADDR_STATUS);
localparam logic [31:0] A_L = 32'(apds_pkg::ADDR_RESULT);
localparam logic [31:0] A_H = 32'(apds_pkg::ADDR_SAMPLE);
localparam logic [33:0] MS = 34'h3_0000_003b;
localparam logic [33:0] MB = 34'h3_0000_1f00;
localparam logic [33:0] MF = 34'h3_ffff_ffff;
localparam logic [33:0] MT = 34'h0_0000_0080;
localparam int SET_INT = 20;
localparam int SET_EXT = 5;
logic aclk = 1'b0, aresetn = 1'b0;
logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
logic analog_on, conv_busy;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [2:0] channel_sel;
logic [3:0] s_axi_wstrb = 4'hf;
logic [11:0] code = 12'h000;
wire logic [11:0] sample_in;
int mismatches = 0, checks_done = 0;
always #12.5 aclk = ~aclk;
apds_core_model u_core (.aclk, .analog_on, .code, .sample_in);
apds_top #(.SETTLE_INT_CYCLES(SET_INT), .SETTLE_EXT_CYCLES(SET_EXT)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sample_in, .channel_sel, .analog_on, .conv_busy);
// ----------------------------------------
// bus and check tasks
// ----------------------------------------
task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
        mismatches++;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] re);
    logic at, wt, bt;
    logic [1:0] r;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
        @(negedge aclk);
        at = s_axi_awvalid && s_axi_awready;
        wt = s_axi_wvalid && s_axi_wready;
        bt = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge aclk);
        if (at) s_axi_awvalid <= 1'b0;
        if (wt) s_axi_wvalid <= 1'b0;
    end while (!bt);
    s_axi_bready <= 1'b0;
    chk(34'(r), 34'(re));
    @(posedge aclk);
endtask
task automatic rchk(input logic [31:0] a, input logic [33:0] m, input logic [33:0] exp);
    logic at, rt;
    logic [33:0] v;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
        @(negedge aclk);
        at = s_axi_arvalid && s_axi_arready;
        rt = s_axi_rvalid;
        v = {s_axi_rresp, s_axi_rdata};
        @(posedge aclk);
        if (at) s_axi_arvalid <= 1'b0;
    end while (!rt);
    s_axi_rready <= 1'b0;
    chk(v & m, exp);
    @(posedge aclk);
endtask
task automatic idle();
    do @(negedge aclk); while (conv_busy);
    @(posedge aclk);
endtask
task automatic pins(input logic [1:0] exp);
    @(negedge aclk);
    chk(34'({analog_on, conv_busy}), 34'(exp));
    @(posedge aclk);
endtask
task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_reset();
    rchk(A_C, MF, 34'hc0);
    rchk(A_S, MS, 34'h10);
    $display("reset test done");
endtask
task automatic t_convert();
    code <= 12'ha5c;
    wr(A_C, 32'hcb, 2'h0);
    chk(34'(channel_sel), 34'h3);
    rchk(A_S, MB, 34'h1300);
    idle();
    rchk(A_L, MF, 34'h5c);
    rchk(A_H, MF, 34'h0a);
    code <= 12'h8a3;
    wr(A_C, 32'hc0, 2'h0);
    idle();
    wr(A_C, 32'hc0, 2'h0);
    rchk(A_S, MB, 34'h1000);
    rchk(A_H, MF, 34'hf8);
    rchk(A_L, MF, 34'ha3);
    idle();
    $display("convert test done");
endtask
task automatic t_standby();
    wr(A_C, 32'h80, 2'h0);
    idle();
    rchk(A_S, MS, 34'h0);
    wr(A_C, 32'h00, 2'h0);
    idle();
    rchk(A_S, MS, 34'h1);
    pins(2'b00);
    wr(A_C, 32'h80, 2'h0);
    pins(2'b10);
    rchk(A_S, MS, 34'h0);
    rchk(A_S, MT, 34'h0);
    repeat (SET_INT) @(posedge aclk);
    rchk(A_S, MT, 34'h80);
    $display("standby test done");
endtask
task automatic t_shutdown();
    wr(A_C, 32'h40, 2'h0);
    rchk(A_S, MS, 34'h28);
    idle();
    pins(2'b00);
    rchk(A_S, MS, 34'h2);
    wr(A_S, 32'h1, apds_pkg::RESP_SLVERR);
    rchk(32'h10, MF, {apds_pkg::RESP_SLVERR, 32'h0});
    wr(A_C, 32'hc0, 2'h0);
    pins(2'b10);
    rchk(A_S, MS, 34'h10);
    wr(A_C, 32'h00, 2'h0);
    idle();
    wr(A_C, 32'hc0, 2'h0);
    rchk(A_S, MT, 34'h0);
    repeat (SET_EXT) @(posedge aclk);
    rchk(A_S, MT, 34'h80);
    $display("shutdown test done");
endtask
initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_convert();
    t_standby();
    t_shutdown();
    stop_test();
end
initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    stop_test();
end
endmodule
`default_nettype wire
